// ==== ring_ctrl_pkg.sv ====
// Shared constants, types and register map of the fibre ring repeater controller
package ring_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned INIT_LAMP_MS   = 100;
  localparam int unsigned INIT_LAMP_CYC  = INIT_LAMP_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned ACT_HOLD_MS    = 5;
  localparam int unsigned ACT_HOLD_CYC   = ACT_HOLD_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned FLICKER_BIT    = 20;
  localparam int unsigned FRAC_BITS      = 16;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  IDLE_TO_OFS    = 8'h04;
  localparam logic [7:0]  RET_TO_OFS     = 8'h08;
  localparam logic [7:0]  STATUS_OFS     = 8'h0c;
  localparam int unsigned CTRL_RING_BIT  = 0;
  localparam int unsigned CTRL_DUAL_BIT  = 1;
  localparam int unsigned CTRL_LIM_LSB   = 4;
  localparam logic        RING_EN_RST    = 1'b1;
  localparam logic        DUAL_RST       = 1'b1;
  localparam logic [3:0]  FAULT_LIM_RST  = 4'h1;
  localparam logic [15:0] IDLE_TO_RST    = 16'hffff;
  localparam logic [15:0] RET_TO_RST     = 16'h2710;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // ----------------------------------------------------------------
  // Supported rates, index is the rate code
  // ----------------------------------------------------------------
  localparam int unsigned NUM_RATES = 10;
  localparam int unsigned RATE_BPS [NUM_RATES] = '{9_600, 19_200, 45_450, 93_750, 187_500,
                                                 500_000, 1_500_000, 3_000_000, 6_000_000,
                                                 12_000_000};

  // Bit periods advanced per clock, fixed point with FRAC_BITS fraction
  function automatic logic [31:0] bit_inc(input logic [3:0] code);
    longint unsigned r;
    r = (code < 4'(NUM_RATES)) ? longint'(RATE_BPS[code]) : longint'(RATE_BPS[0]);
    return 32'((r << FRAC_BITS) / CLK_HZ);
  endfunction

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    M_INIT      = 5'b00001,
    M_LINK_WAIT = 5'b00010,
    M_RING_A    = 5'b00100,
    M_RING_AB   = 5'b01000,
    M_MULTIDROP = 5'b10000
  } mode_e;

  // One frame-level event from a deserialiser (0 bus, 1 port one, 2 port two)
  typedef struct packed {
    logic       start;
    logic       good;
    logic       bad;
    logic       own;
    logic [3:0] rate;
  } frame_ev_s;

  typedef struct packed {
    logic rx_ok;
    logic tx_ok;
    logic low_power;
  } port_stat_s;

endpackage

// ==== fibre_ring_repeater_ctrl.sv ====
// Frame-level ring, rate-lock and alarm controller with AXI4-Lite registers
`timescale 1ns/10ps

// Notes on behaviour
// R1 - Lock rate on first good frame, any port
// R2 - Rates 9600 bit/s to 12 Mbit/s
// R3 - Unlock on faulty frames or idle timeout
// R4 - Transmit on own bit timing, not received
// R5 - Repeat frames between the two fibre ports
// R6 - No ring fault: send on ring A only
// R7 - Ring fault: send on rings A and B
// R8 - Ring A leaves port one, B enters there
// R9 - Own bus frame suspends repeating until return
// R10 - Foreign ring frame: repeat and convert to bus
// R11 - Slave reply sent likewise, suspends until return
// R12 - Return or timeout re-enables conversion
// R13 - Ring A down ring B; both multidrop
// R14 - Remote LED transmit fault, local receive; flicker
// R15 - Recover automatically when faults clear
// R16 - Multidrop: both ports, or port one only
// R17 - Multidrop: repeat to other port and bus
// R18 - Lamp test, link start, alarm until ready
// R19 - Fibre transfer only when linked and locked
// R20 - Link loss: local and remote alarm, auto clear
// R21 - Activity LED on frames while rate locked
// R22 - Return timeout counted in detected bit periods
// R23 - Relay in fault while any alarm active
module fibre_ring_repeater_ctrl
  import ring_ctrl_pkg::*;
#(
  parameter int unsigned INIT_CYC = INIT_LAMP_CYC,
  parameter int unsigned ACT_CYC  = ACT_HOLD_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire frame_ev_s [2:0]   rx_ev,
  input  wire port_stat_s [1:0]  port_stat,
  output logic                   conv_to_bus,
  output logic                   send_port_one,
  output logic                   send_port_two,
  output logic                   rep_two_to_one,
  output logic                   rep_one_to_two,
  output logic                   bit_tick,
  output logic                   remote_fault_led,
  output logic                   local_fault_led,
  output logic                   bus_active_led,
  output logic                   relay_fault,
  output logic [1:0]             remote_alarm_tx
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mode_e       mode;
    logic [23:0] init_cnt;
    logic        locked;
    logic [3:0]  rate;
    logic [15:0] frac;
    logic [16:0] idle_bits;
    logic [3:0]  bad_cnt;
    logic        suspend;
    logic [16:0] ret_bits;
    logic [23:0] act_cnt;
    logic [20:0] flick;
    logic        ring_en, dual;
    logic [3:0]  fault_lim;
    logic [15:0] idle_to, ret_to;
    logic        aw_hold, w_hold;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid;
    logic [1:0]  bresp;
    logic        arready, rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        conv, send1, send2, rep21, rep12, tick;
    logic        rled, lled, aled, relay;
    logic [1:0]  ralarm;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic        ring_a_ok, ring_b_ok, links_up, own_back;
  logic        any_start, any_good, any_bad;
  logic [1:0]  used, link_ok;
  logic [32:0] acc;
  logic [16:0] ticks;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // Link conditions
  // ----------------------------------------------------------------
  always_comb begin
    used        = {st_reg.dual, 1'b1};
    link_ok[0]  = port_stat[0].rx_ok & port_stat[0].tx_ok;
    link_ok[1]  = port_stat[1].rx_ok & port_stat[1].tx_ok;
    links_up    = &(link_ok | ~used);
    ring_a_ok   = port_stat[0].tx_ok & port_stat[1].rx_ok;  // see R8
    ring_b_ok   = port_stat[1].tx_ok & port_stat[0].rx_ok;  // see R8
    any_start   = rx_ev[0].start | rx_ev[1].start | rx_ev[2].start;
    any_good    = rx_ev[0].good | rx_ev[1].good | rx_ev[2].good;
    any_bad     = rx_ev[0].bad | rx_ev[1].bad | rx_ev[2].bad;
    own_back    = rx_ev[2].good & rx_ev[2].own;              // Ring A returns on port two
    status_word = {16'h0000, 3'b000, st_reg.mode, st_reg.suspend, st_reg.locked, 2'b00,
                   st_reg.rate};
  end

  // Bit-period advance at the locked rate; at 12 Mbit/s the advance reaches two ticks per clock
  always_comb begin
    acc   = {17'h00000, st_reg.frac} + {1'b0, bit_inc(st_reg.rate)};  // see R2
    ticks = acc[32:16];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_hold = 1'b1;
      st_next.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_hold = 1'b1;
      st_next.wdata  = s_axi_wdata;
      st_next.wstrb  = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) st_next.bvalid = 1'b0;
    if (st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid) begin
      st_next.aw_hold = 1'b0;
      st_next.w_hold  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = RESP_OKAY;
      unique case (st_reg.awaddr)
        CTRL_OFS: if (st_reg.wstrb[0]) begin
          st_next.ring_en   = st_reg.wdata[CTRL_RING_BIT];
          st_next.dual      = st_reg.wdata[CTRL_DUAL_BIT];
          st_next.fault_lim = st_reg.wdata[CTRL_LIM_LSB +: 4];
        end
        IDLE_TO_OFS: begin
          if (st_reg.wstrb[0]) st_next.idle_to[7:0]  = st_reg.wdata[7:0];
          if (st_reg.wstrb[1]) st_next.idle_to[15:8] = st_reg.wdata[15:8];
        end
        RET_TO_OFS: begin
          if (st_reg.wstrb[0]) st_next.ret_to[7:0]  = st_reg.wdata[7:0];
          if (st_reg.wstrb[1]) st_next.ret_to[15:8] = st_reg.wdata[15:8];
        end
        STATUS_OFS: st_next.bresp = RESP_SLVERR;
        default:    st_next.bresp = RESP_SLVERR;
      endcase
    end
    st_next.awready = !st_next.aw_hold && !st_next.bvalid;
    st_next.wready  = !st_next.w_hold && !st_next.bvalid;

    // AXI4-Lite read
    if (st_reg.rvalid && s_axi_rready) st_next.rvalid = 1'b0;
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFS:    st_next.rdata = {24'h000000, st_reg.fault_lim, 2'b00, st_reg.dual,
                                      st_reg.ring_en};
        IDLE_TO_OFS: st_next.rdata = {16'h0000, st_reg.idle_to};
        RET_TO_OFS:  st_next.rdata = {16'h0000, st_reg.ret_to};
        STATUS_OFS:  st_next.rdata = status_word;
        default: begin
          st_next.rdata = 32'h00000000;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    st_next.arready = !st_next.rvalid;

    // Bit timing of the locked rate drives the transmit strobe
    st_next.frac = acc[15:0];
    st_next.tick = st_reg.locked && (ticks != 17'h00000);  // see R4

    // Rate lock
    if (!st_reg.locked) begin
      st_next.idle_bits = 17'h00000;
      st_next.bad_cnt   = 4'h0;
      for (int i = 2; i >= 0; i--) begin
        if (rx_ev[i].good && rx_ev[i].rate < 4'(NUM_RATES)) begin  // see R1
          st_next.locked = 1'b1;
          st_next.rate   = rx_ev[i].rate;
        end
      end
    end else begin
      if (any_start) begin
        st_next.idle_bits = 17'h00000;
      end else if (st_reg.idle_bits < 17'h1ffff) begin
        st_next.idle_bits = st_reg.idle_bits + ticks;
      end
      if (any_good) st_next.bad_cnt = 4'h0;
      else if (any_bad) st_next.bad_cnt = st_reg.bad_cnt + 4'h1;
      // A zero limit is treated as one
      if ((any_bad && !any_good && st_reg.bad_cnt + 4'h1 >= st_reg.fault_lim) ||
          st_reg.idle_bits >= {1'b0, st_reg.idle_to}) begin  // see R3
        st_next.locked    = 1'b0;
        st_next.idle_bits = 17'h00000;
        st_next.bad_cnt   = 4'h0;
      end
    end

    // Own-frame suspension; return timeout in bit periods
    if (st_reg.suspend) begin
      st_next.ret_bits = st_reg.ret_bits + ticks;  // see R22
      if (own_back || st_reg.ret_bits >= {1'b0, st_reg.ret_to}) begin
        st_next.suspend  = 1'b0;  // see R12
        st_next.ret_bits = 17'h00000;
      end
    end
    if (rx_ev[0].good && st_reg.locked && st_reg.send1 &&
        (st_reg.mode == M_RING_A || st_reg.mode == M_RING_AB)) begin
      st_next.suspend  = 1'b1;  // see R9 R11
      st_next.ret_bits = 17'h00000;
    end

    // Operating mode
    if (st_reg.init_cnt != 24'h000000) st_next.init_cnt = st_reg.init_cnt - 24'h000001;
    unique case (st_reg.mode)
      M_INIT: if (st_reg.init_cnt == 24'h000000) st_next.mode = M_LINK_WAIT;  // see R18
      M_LINK_WAIT: if (links_up) st_next.mode = st_reg.ring_en ? M_RING_A : M_MULTIDROP;
      M_RING_A, M_RING_AB, M_MULTIDROP: begin
        if (!st_reg.ring_en) st_next.mode = M_MULTIDROP;
        else if (!ring_a_ok && !ring_b_ok) st_next.mode = M_MULTIDROP;  // see R13
        else if (!ring_a_ok) st_next.mode = M_RING_AB;  // see R7 R13
        else st_next.mode = M_RING_A;  // see R6 R15
      end
    endcase
    if (st_next.mode != M_RING_A && st_next.mode != M_RING_AB) begin
      st_next.suspend = 1'b0;
    end

    // Routing of converted and repeated frames
    st_next.send1 = 1'b0;
    st_next.send2 = 1'b0;
    st_next.rep21 = 1'b0;
    st_next.rep12 = 1'b0;
    st_next.conv  = 1'b0;
    if (st_reg.locked) begin  // see R19
      unique case (st_reg.mode)
        M_RING_A: begin
          st_next.send1 = 1'b1;  // see R6 R8
          st_next.rep21 = !st_reg.suspend;  // see R5 R9 R10
          st_next.conv  = !st_reg.suspend;  // see R10 R12
        end
        M_RING_AB: begin
          st_next.send1 = 1'b1;  // see R7
          st_next.send2 = 1'b1;
          st_next.rep21 = !st_reg.suspend;
          st_next.rep12 = !st_reg.suspend;  // see R5
          st_next.conv  = !st_reg.suspend;
        end
        M_MULTIDROP: begin
          st_next.send1 = link_ok[0];  // see R16
          st_next.send2 = st_reg.dual && link_ok[1];
          st_next.rep21 = st_reg.dual && link_ok[0];  // see R17
          st_next.rep12 = st_reg.dual && link_ok[1];
          st_next.conv  = 1'b1;  // see R17
        end
        default: ;
      endcase
    end

    // Indicators and alarms
    st_next.flick = st_reg.flick + 21'h000001;
    if (st_reg.locked && any_start) begin
      st_next.act_cnt = 24'(ACT_CYC);  // see R21
    end else if (st_reg.act_cnt != 24'h000000) begin
      st_next.act_cnt = st_reg.act_cnt - 24'h000001;
    end
    if (st_reg.mode == M_INIT) begin
      st_next.rled   = 1'b1;  // see R18
      st_next.lled   = 1'b1;
      st_next.aled   = 1'b1;
      st_next.relay  = 1'b1;
      st_next.ralarm = 2'b00;
    end else begin
      // A receive break outranks a transmit break: combined shows local only
      st_next.rled = (|(~{port_stat[1].tx_ok, port_stat[0].tx_ok} & used)) &&
                     !(|(~{port_stat[1].rx_ok, port_stat[0].rx_ok} & used));  // see R14
      st_next.lled = (|(~{port_stat[1].rx_ok, port_stat[0].rx_ok} & used)) ||
                     ((|{port_stat[1].low_power, port_stat[0].low_power}) &&
                      st_reg.flick[FLICKER_BIT]);  // see R14
      st_next.aled = st_reg.locked && st_next.act_cnt != 24'h000000;  // see R21
      // Link loss on one port is reported to the far end over the other port
      st_next.ralarm[0] = used[1] && !link_ok[1];  // see R20
      st_next.ralarm[1] = used[1] && !link_ok[0];  // see R20
      st_next.relay = (st_reg.mode == M_LINK_WAIT) || !links_up;  // see R18 R20 R23
    end
  end

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg           <= '0;
      st_reg.mode      <= M_INIT;
      st_reg.init_cnt  <= 24'(INIT_CYC);
      st_reg.ring_en   <= RING_EN_RST;
      st_reg.dual      <= DUAL_RST;
      st_reg.fault_lim <= FAULT_LIM_RST;
      st_reg.idle_to   <= IDLE_TO_RST;
      st_reg.ret_to    <= RET_TO_RST;
      st_reg.relay     <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready    = st_reg.awready;
  assign s_axi_wready     = st_reg.wready;
  assign s_axi_bvalid     = st_reg.bvalid;
  assign s_axi_bresp      = st_reg.bresp;
  assign s_axi_arready    = st_reg.arready;
  assign s_axi_rvalid     = st_reg.rvalid;
  assign s_axi_rresp      = st_reg.rresp;
  assign s_axi_rdata      = st_reg.rdata;
  assign conv_to_bus      = st_reg.conv;
  assign send_port_one    = st_reg.send1;
  assign send_port_two    = st_reg.send2;
  assign rep_two_to_one   = st_reg.rep21;
  assign rep_one_to_two   = st_reg.rep12;
  assign bit_tick         = st_reg.tick;
  assign remote_fault_led = st_reg.rled;
  assign local_fault_led  = st_reg.lled;
  assign bus_active_led   = st_reg.aled;
  assign relay_fault      = st_reg.relay;
  assign remote_alarm_tx  = st_reg.ralarm;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence own_sent_s;
    rx_ev[0].good && st_reg.locked && st_reg.send1 && st_reg.mode == M_RING_A;
  endsequence
  sequence held_off_s;
    st_reg.suspend && !rx_ev[0].good;
  endsequence

  rate_lock_a: assert property (!st_reg.locked && rx_ev[1].good && !rx_ev[0].good &&
                                !rx_ev[2].good && rx_ev[1].rate < 4'(NUM_RATES)
                                |=> st_reg.locked && st_reg.rate == $past(rx_ev[1].rate))  // see R1
    else $error("rate not locked on good frame");
  bad_unlock_a: assert property (st_reg.locked && st_reg.fault_lim == 4'h1 && any_bad &&
                                 !any_good |=> !st_reg.locked)  // see R3
    else $error("rate kept after faulty frame");
  ring_a_only_a: assert property (st_reg.mode == M_RING_A && st_reg.locked
                                  |=> st_reg.send1 && !st_reg.send2)  // see R6
    else $error("ring A send wrong");
  ring_ab_a: assert property (st_reg.mode == M_RING_AB && st_reg.locked
                              |=> st_reg.send1 && st_reg.send2)  // see R7
    else $error("ring A and B send wrong");
  suspend_rep_a: assert property (own_sent_s ##1 held_off_s |=> !st_reg.rep21 && !st_reg.conv)  // see R9
    else $error("repeating while own frame out");
  own_return_a: assert property (st_reg.suspend && own_back && !rx_ev[0].good |=> !st_reg.suspend)  // see R12
    else $error("own frame return ignored");
  both_down_a: assert property (st_reg.mode == M_RING_A && !ring_a_ok && !ring_b_ok
                                |=> st_reg.mode == M_MULTIDROP)  // see R13
    else $error("no multidrop on double break");
  no_lock_send_a: assert property (!st_reg.locked |=> !st_reg.send1 && !st_reg.rep21)  // see R19
    else $error("fibre transfer while unlocked");
  lamp_test_a: assert property (st_reg.mode == M_INIT |=> st_reg.rled && st_reg.lled &&
                                st_reg.relay)  // see R18
    else $error("lamp test not all on");
  relay_fault_a: assert property (st_reg.mode != M_INIT && !links_up |=> st_reg.relay)  // see R23
    else $error("relay released with link down");

endmodule

// ==== ring_far_side.sv ====
// Far-side model: neighbour nodes and the fibre ring seen from this node
`timescale 1ns/10ps
module ring_far_side
  import ring_ctrl_pkg::*;
#(
  parameter int unsigned RET_DLY = 5
) (
  input  wire logic        aclk,
  input  wire logic        send_port_one,
  input  wire logic [3:0]  link_cfg,
  input  wire logic        sent,
  input  wire logic        good_one,
  input  wire logic        bad_one,
  input  wire logic [3:0]  rate,
  output port_stat_s [1:0] port_stat,
  output frame_ev_s        ev_one,
  output frame_ev_s        ev_two
);
  // Ring delay line; only frames put on port one come back
  logic [RET_DLY-1:0] ret_sr = '0;

  always_ff @(posedge aclk) ret_sr <= {ret_sr[RET_DLY-2:0], sent & send_port_one};

  // Own frame comes home on port two, the end of ring A
  assign ev_two = {1'b0, ret_sr[RET_DLY-1], 1'b0, ret_sr[RET_DLY-1], rate};
  assign ev_one = {good_one | bad_one, good_one, bad_one, 1'b0, rate};
  assign port_stat[0] = {link_cfg[0], link_cfg[1], 1'b0};
  assign port_stat[1] = {link_cfg[2], link_cfg[3], 1'b0};
endmodule

// ==== fibre_ring_repeater_ctrl_bench.sv ====
// Bench: register access, rate lock, ring routing and fault handling
`timescale 1ns/10ps
module fibre_ring_repeater_ctrl_bench
  import ring_ctrl_pkg::*;
;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [7:0]       s_axi_awaddr = 8'h00;
  logic [7:0]       s_axi_araddr = 8'h00;
  logic [31:0]      s_axi_wdata = 32'h0;
  logic [3:0]       s_axi_wstrb = 4'hf;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]       s_axi_bresp, s_axi_rresp, remote_alarm_tx, rs;
  logic [31:0]      s_axi_rdata, rd;
  logic             conv_to_bus, send_port_one, send_port_two, rep_two_to_one, rep_one_to_two;
  logic             bit_tick, remote_fault_led, local_fault_led, bus_active_led, relay_fault;
  frame_ev_s        bus_ev = '0, ev_one, ev_two;
  port_stat_s [1:0] port_stat;
  logic [3:0]       link_cfg = 4'hf;
  logic             good_one = 1'b0, bad_one = 1'b0;
  logic [7:0]       ofs [3] = '{CTRL_OFS, IDLE_TO_OFS, RET_TO_OFS};
  logic [31:0]      rst_val [3] = '{{24'h0, FAULT_LIM_RST, 2'b00, DUAL_RST, RING_EN_RST},
                                    {16'h0, IDLE_TO_RST}, {16'h0, RET_TO_RST}};
  int               n_errors = 0, samples_checked = 0;
  int               n_ticks = 0, t0 = 0;

  always #50 aclk = ~aclk;
  always @(posedge aclk) n_ticks <= n_ticks + int'(bit_tick);

  fibre_ring_repeater_ctrl #(.INIT_CYC(8), .ACT_CYC(16)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rx_ev({ev_two, ev_one, bus_ev}), .port_stat, .conv_to_bus, .send_port_one, .send_port_two,
    .rep_two_to_one, .rep_one_to_two, .bit_tick, .remote_fault_led, .local_fault_led,
    .bus_active_led, .relay_fault, .remote_alarm_tx);

  ring_far_side #(.RET_DLY(5)) far_u (.aclk, .send_port_one, .link_cfg, .sent(bus_ev.good),
    .good_one, .bad_one, .rate(4'h6), .port_stat, .ev_one, .ev_two);

  // --------------------
  // Tasks
  // --------------------
  // Trailing delay lets the edge's register updates land before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      aw_done |= s_axi_awready;
      w_done |= s_axi_wready;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse_one(input logic g);
    @(posedge aclk);
    good_one <= g;
    bad_one <= !g;
    @(posedge aclk);
    good_one <= 1'b0;
    bad_one <= 1'b0;
  endtask

  task automatic set_links(input logic [3:0] v);
    @(posedge aclk);
    link_cfg <= v;
  endtask

  task automatic give_verdict;
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // --------------------
  // Tests
  // --------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    chk("init_local_led", 1, local_fault_led);
    chk("init_remote_led", 1, remote_fault_led);
    chk("init_relay", 1, relay_fault);
    tick(20);
    chk("ready_relay", 0, relay_fault);
    chk("unlocked_send", 0, send_port_one);
    foreach (ofs[i]) begin
      axi_rd(ofs[i]);
      chk("reset_value", rst_val[i], rd);
    end
    axi_rd(8'h10);
    chk("unmapped_resp", RESP_SLVERR, rs);
    chk("unmapped_data", 0, rd);
    axi_wr(STATUS_OFS, 32'h0);
    chk("status_wr_resp", RESP_SLVERR, rs);
    axi_wr(RET_TO_OFS, 32'habcd_0100);
    axi_rd(RET_TO_OFS);
    chk("ret_to", 32'h100, rd);
    pulse_one(1'b1);
    tick(2);
    chk("lock_send_one", 1, send_port_one);
    chk("lock_send_two", 0, send_port_two);
    chk("lock_repeat", 1, rep_two_to_one);
    chk("lock_conv", 1, conv_to_bus);
    axi_rd(STATUS_OFS);
    chk("status", 32'h0446, rd & 32'h1fcf);
    pulse_bus();
    tick(2);
    chk("susp_conv", 0, conv_to_bus);
    chk("susp_repeat", 0, rep_two_to_one);
    chk("bus_led", 1, bus_active_led);
    tick(5);
    chk("return_conv", 1, conv_to_bus);
    set_links(4'b1101);
    tick(3);
    chk("fault_send_two", 1, send_port_two);
    chk("fault_remote_led", 1, remote_fault_led);
    chk("fault_relay", 1, relay_fault);
    chk("fault_ralarm", 2'b10, remote_alarm_tx);
    set_links(4'hf);
    tick(3);
    chk("recover_two", 0, send_port_two);
    set_links(4'b1100);
    tick(3);
    chk("md_local_led", 1, local_fault_led);
    chk("md_send_two", 1, send_port_two);
    chk("md_rep", 1, rep_one_to_two);
    axi_rd(STATUS_OFS);
    chk("md_mode", 32'h10, (rd >> 8) & 32'h1f);
    set_links(4'hf);
    tick(3);
    axi_rd(STATUS_OFS);
    chk("back_mode", 32'h04, (rd >> 8) & 32'h1f);
    // 1.5 Mbit/s is 150 bit periods per 1000 clocks; the truncated step may lose one
    t0 = n_ticks;
    tick(1000);
    chk("tick_rate", 1, (n_ticks - t0) inside {[149:150]});
    axi_wr(CTRL_OFS, 32'h10);
    tick(2);
    chk("single_send_one", 1, send_port_one);
    chk("single_send_two", 0, send_port_two);
    pulse_one(1'b0);
    tick(2);
    axi_rd(STATUS_OFS);
    chk("unlock", 0, rd[6]);
    chk("unlock_send", 0, send_port_one);
    give_verdict();
  end

  task automatic pulse_bus;
    @(posedge aclk);
    bus_ev <= '{start: 1'b1, good: 1'b1, bad: 1'b0, own: 1'b0, rate: 4'h6};
    @(posedge aclk);
    bus_ev <= '0;
  endtask

  // Run needs about 1 100 cycles; far longer means a hang
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end
endmodule
